/* window_watchdog_pkg.sv */
// Operation
// - Watchdog idle while rail or global fault
// - Plain variant: fault holds reset delay plus three ticks
// - Reset release starts long first timeout
// - No trigger edge before timeout is fault
// - First trigger edge starts both windows
// - Edge inside closed window is fault
// - Edge must land in open window
// - Trigger stuck high whole period is fault
// - Trigger high at release starts windows
// - Plain variant: reset only, regulators run
// - Shutdown variant: regulators off, then restart
// - Intervals counted on watchdog oscillator ticks
// - Timing pin low, sync high: debug
// - Debug mode never raises watchdog fault
// - Either strap released ends debug mode
// - Timing pin low without sync: fault
// - Rail out of window asserts reset
package window_watchdog_pkg;

  localparam int CNT_W = 16;

  // ----------------------------------------
  // Default intervals in watchdog ticks
  // ----------------------------------------
  localparam logic [15:0] FIRST_TICKS_DEF = 16'h0258;
  localparam logic [15:0] CLOSED_TICKS_DEF = 16'h000A;
  localparam logic [15:0] OPEN_TICKS_DEF = 16'h0028;
  localparam logic [15:0] RESET_TICKS_DEF = 16'h0020;
  localparam logic [15:0] ENABLE_TICKS_DEF = 16'h0040;
  localparam logic [15:0] EXTRA_TICKS = 16'h0003;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    WD_OFF    = 2'b00,
    WD_FIRST  = 2'b01,
    WD_WINDOW = 2'b10
  } wd_state_type;

  // Raw pins and analog comparator levels
  typedef struct packed {
    logic trigger;
    logic sync_clock;
    logic timing_low;
    logic rail1_ok;
    logic global_fault;
    logic osc;
  } pin_in_type;

  localparam pin_in_type PIN_RESET = 6'h00;

endpackage

/* window_watchdog_supervisor.sv */
`timescale 1ns/100ps
module window_watchdog_supervisor #(
  parameter bit          SHUTDOWN     = 1'b0,
  parameter logic [15:0] FIRST_TICKS  = window_watchdog_pkg::FIRST_TICKS_DEF,
  parameter logic [15:0] CLOSED_TICKS = window_watchdog_pkg::CLOSED_TICKS_DEF,
  parameter logic [15:0] OPEN_TICKS   = window_watchdog_pkg::OPEN_TICKS_DEF,
  parameter logic [15:0] RESET_TICKS  = window_watchdog_pkg::RESET_TICKS_DEF,
  parameter logic [15:0] ENABLE_TICKS = window_watchdog_pkg::ENABLE_TICKS_DEF
) (
  input  wire logic                            ref_clk_i,
  input  wire logic                            reset_n_i,
  input  wire logic                            clk_en_i,
  input  wire window_watchdog_pkg::pin_in_type pins_i,
  output logic                                 primary_reset_out_o,
  output logic                                 primary_reset_oe_n_o,
  output logic                                 regulators_enable_o,
  output logic                                 spread_spectrum_off_o,
  output logic                                 watchdog_fault_o
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  window_watchdog_pkg::pin_in_type s1, s2, s3, lvl;
  window_watchdog_pkg::wd_state_type wd_state;
  logic [15:0] main_cnt;
  logic [15:0] closed_cnt;
  logic [15:0] high_cnt;
  logic [15:0] rel_cnt;
  logic [15:0] dis_cnt;
  logic        osc_d;
  logic        trig_d;
  logic        reset_rel;
  logic        reset_rel_d;
  logic        tick;
  logic        trig_rise;
  logic        debug;
  logic        pin_fault;
  logic        cause;
  logic        release_edge;
  logic        wd_active;
  logic        first_exp;
  logic        open_exp;
  logic        closed_hit;
  logic        stuck;
  logic        fault_now;
  logic [15:0] period;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Three stages, level moves when stages two and three agree
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1  <= window_watchdog_pkg::PIN_RESET;
      s2  <= window_watchdog_pkg::PIN_RESET;
      s3  <= window_watchdog_pkg::PIN_RESET;
      lvl <= window_watchdog_pkg::PIN_RESET;
    end else if (clk_en_i) begin
      s1  <= pins_i;
      s2  <= s1;
      s3  <= s2;
      lvl <= (s3 & ~(s2 ^ s3)) | (lvl & (s2 ^ s3));
    end
  end

  // Edge history of oscillator, trigger and reset
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      osc_d       <= 1'b0;
      trig_d      <= 1'b0;
      reset_rel_d <= 1'b0;
    end else if (clk_en_i) begin
      osc_d       <= lvl.osc;
      trig_d      <= lvl.trigger;
      reset_rel_d <= reset_rel;
    end
  end

  assign tick         = lvl.osc && !osc_d;
  assign trig_rise    = lvl.trigger && !trig_d;
  assign release_edge = reset_rel && !reset_rel_d;

  // ----------------------------------------
  // Debug straps
  // ----------------------------------------
  // debug while both straps hold
  assign debug     = lvl.timing_low && lvl.sync_clock;
  // timing strap alone is a fault
  assign pin_fault = lvl.timing_low && !lvl.sync_clock;
  assign spread_spectrum_off_o = debug;

  // ----------------------------------------
  // Fault detection
  // ----------------------------------------
  // watchdog only runs released, not debug
  assign wd_active  = (wd_state != window_watchdog_pkg::WD_OFF) && reset_rel && !debug;
  assign period     = (wd_state == window_watchdog_pkg::WD_FIRST) ? FIRST_TICKS : OPEN_TICKS;
  assign first_exp  = (wd_state == window_watchdog_pkg::WD_FIRST) && tick
                      && (main_cnt == 16'h0001) && !trig_rise;
  assign open_exp   = (wd_state == window_watchdog_pkg::WD_WINDOW) && tick
                      && (main_cnt == 16'h0001) && !trig_rise;
  assign closed_hit = (wd_state == window_watchdog_pkg::WD_WINDOW) && trig_rise
                      && (closed_cnt != 16'h0000);
  assign stuck      = lvl.trigger && (high_cnt >= period);
  assign fault_now  = wd_active && (first_exp || open_exp || closed_hit || stuck);
  assign watchdog_fault_o = fault_now;

  // ----------------------------------------
  // Window state machine
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wd_state   <= window_watchdog_pkg::WD_OFF;
      main_cnt   <= 16'h0000;
      closed_cnt <= 16'h0000;
    end else if (clk_en_i) begin
      case (wd_state)
        window_watchdog_pkg::WD_OFF: begin
          if (release_edge && !debug) begin
            if (lvl.trigger) begin
              // high at release acts as pulse
              wd_state   <= window_watchdog_pkg::WD_WINDOW;
              main_cnt   <= OPEN_TICKS;
              closed_cnt <= CLOSED_TICKS;
            end else begin
              wd_state <= window_watchdog_pkg::WD_FIRST;
              main_cnt <= FIRST_TICKS;
            end
          end
        end
        window_watchdog_pkg::WD_FIRST,
        window_watchdog_pkg::WD_WINDOW: begin
          if (!reset_rel || debug || fault_now) begin
            wd_state <= window_watchdog_pkg::WD_OFF;
          end else if (trig_rise) begin
            wd_state   <= window_watchdog_pkg::WD_WINDOW;
            main_cnt   <= OPEN_TICKS;
            closed_cnt <= CLOSED_TICKS;
          end else if (tick) begin
            main_cnt <= main_cnt - 16'h0001;
            if (closed_cnt != 16'h0000) begin
              closed_cnt <= closed_cnt - 16'h0001;
            end
          end
        end
        default: wd_state <= window_watchdog_pkg::WD_OFF;
      endcase
    end
  end

  // Ticks of continuous trigger high
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      high_cnt <= 16'h0000;
    end else if (clk_en_i) begin
      if (!lvl.trigger || trig_rise || !wd_active) begin
        high_cnt <= 16'h0000;
      end else if (tick && high_cnt != 16'hFFFF) begin
        high_cnt <= high_cnt + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Regulator shutdown
  // ----------------------------------------
  // disable window only in shutdown build
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dis_cnt <= 16'h0000;
    end else if (clk_en_i) begin
      if (SHUTDOWN && fault_now) begin
        dis_cnt <= ENABLE_TICKS;
      end else if (tick && dis_cnt != 16'h0000) begin
        dis_cnt <= dis_cnt - 16'h0001;
      end
    end
  end

  assign regulators_enable_o = (dis_cnt == 16'h0000);

  // ----------------------------------------
  // Primary reset
  // ----------------------------------------
  // causes holding reset low
  assign cause = !lvl.rail1_ok || lvl.global_fault || pin_fault
                 || (dis_cnt != 16'h0000);

  // Release delay after last cause
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rel_cnt <= 16'h0000;
    end else if (clk_en_i) begin
      if (fault_now && !SHUTDOWN) begin
        rel_cnt <= 16'(RESET_TICKS + window_watchdog_pkg::EXTRA_TICKS);
      end else if (cause) begin
        rel_cnt <= RESET_TICKS;
      end else if (tick && rel_cnt != 16'h0000) begin
        rel_cnt <= rel_cnt - 16'h0001;
      end
    end
  end

  // Released level of the open-drain reset
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reset_rel <= 1'b0;
    end else if (clk_en_i) begin
      reset_rel <= !cause && !fault_now && (rel_cnt == 16'h0000);
    end
  end

  assign primary_reset_out_o  = 1'b0;
  assign primary_reset_oe_n_o = reset_rel;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_idle_on_rail;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      clk_en_i && !lvl.rail1_ok |=> !wd_active;
  endproperty
  a_idle_on_rail: assert property (p_idle_on_rail)
    else $error("watchdog active with rail out");

  property p_extra;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      clk_en_i && fault_now && !SHUTDOWN |=> rel_cnt == RESET_TICKS + 16'h0003;
  endproperty
  a_extra: assert property (p_extra)
    else $error("reset hold not delay plus three");

  property p_first;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      clk_en_i && release_edge && !debug && !lvl.trigger
      |=> wd_state == window_watchdog_pkg::WD_FIRST && main_cnt == FIRST_TICKS;
  endproperty
  a_first: assert property (p_first)
    else $error("first timeout not started");

  property p_timeout;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      clk_en_i && wd_active && first_exp |=> !primary_reset_oe_n_o;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("missed first edge kept reset high");

  property p_early;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      wd_active && wd_state == window_watchdog_pkg::WD_WINDOW && trig_rise
      && closed_cnt != 16'h0000 |-> fault_now;
  endproperty
  a_early: assert property (p_early)
    else $error("early edge not faulted");

  property p_high_start;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      clk_en_i && release_edge && !debug && lvl.trigger
      |=> wd_state == window_watchdog_pkg::WD_WINDOW && closed_cnt == CLOSED_TICKS;
  endproperty
  a_high_start: assert property (p_high_start)
    else $error("high trigger at release not a pulse");

  property p_plain;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      SHUTDOWN || regulators_enable_o;
  endproperty
  a_plain: assert property (p_plain)
    else $error("regulators off in plain build");

  property p_shut;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      clk_en_i && SHUTDOWN && fault_now |=> !regulators_enable_o ##1 !primary_reset_oe_n_o;
  endproperty
  a_shut: assert property (p_shut)
    else $error("shutdown fault left regulators on");

  property p_debug;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      debug |-> !fault_now && spread_spectrum_off_o;
  endproperty
  a_debug: assert property (p_debug)
    else $error("fault raised in debug mode");

  property p_pin_fault;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      clk_en_i && pin_fault |=> !primary_reset_oe_n_o;
  endproperty
  a_pin_fault: assert property (p_pin_fault)
    else $error("timing strap fault not reported");

  c_release: cover property (@(posedge ref_clk_i) release_edge);
  c_restart: cover property (@(posedge ref_clk_i)
    wd_active && trig_rise && closed_cnt == 16'h0000);
  c_fault: cover property (@(posedge ref_clk_i) fault_now);
  c_debug: cover property (@(posedge ref_clk_i) debug);

endmodule

/* host_trigger_model.sv */
`timescale 1ns/100ps
// Host side: silent, periodic or stuck-high trigger
module host_trigger_model (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        released_i,
  input  wire logic [1:0]  mode_i,
  input  wire logic [15:0] period_i,
  output logic             trigger_o
);
  logic [15:0] cnt;

  // --------------------------------
  // Trigger pulse generator
  // --------------------------------
  // period set by bench
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt       <= 16'h0000;
      trigger_o <= 1'h0;
    end else if (!released_i || mode_i != 2'h1) begin
      cnt       <= 16'h0000;
      trigger_o <= (mode_i == 2'h2); // Stuck high ignores reset pin
    end else begin
      cnt       <= (cnt + 16'h0001 >= period_i) ? 16'h0000 : cnt + 16'h0001;
      trigger_o <= (cnt < 16'h0004); // High four clocks per period
    end
  end
endmodule

/* test_window_watchdog_supervisor.sv */
`timescale 1ns/100ps
module test_window_watchdog_supervisor;
  localparam logic [15:0] F = 16'h0014;
  localparam logic [15:0] C = 16'h0003;
  localparam logic [15:0] O = 16'h0008;
  localparam logic [15:0] R = 16'h0004;
  localparam logic [15:0] E = 16'h0005;
  logic        clk     = 1'h0;
  logic        reset_n = 1'h0;
  logic        sync_v  = 1'h0;
  logic        tlow_v  = 1'h0;
  logic        rail_v  = 1'h1;
  logic        gflt_v  = 1'h0;
  logic        osc_v   = 1'h0;
  logic [31:0] oc      = 32'h0000_0000;
  logic [1:0]  mode    = 2'h0;
  logic [15:0] per     = 16'h0010;
  logic        trig;
  logic        oe_n;
  logic        reg_en;
  logic        ss_off;
  logic        fault;
  logic        oe_n_sd;
  logic        reg_en_sd;
  logic        rst_out;
  int          n_fail      = 0;
  int          checks_done = 0;
  integer      seed        = 32'h420B;
  int          tbl[6]      = '{1, 2, 5, 6, 11, 12};
  window_watchdog_pkg::pin_in_type pins;

  // --------------------------------
  // Clock, oscillator, pins
  // --------------------------------
  always #4 clk = ~clk;
  // Watchdog tick every eight clocks
  always @(posedge clk) begin
    oc    <= oc + 32'h0000_0001;
    osc_v <= oc[2];
  end
  assign pins = {trig, sync_v, tlow_v, rail_v, gflt_v, osc_v};

  window_watchdog_supervisor #(
    .SHUTDOWN     (1'h0),
    .FIRST_TICKS  (F),
    .CLOSED_TICKS (C),
    .OPEN_TICKS   (O),
    .RESET_TICKS  (R),
    .ENABLE_TICKS (E)
  ) i_dut (
    .ref_clk_i             (clk),
    .reset_n_i             (reset_n),
    .clk_en_i              (1'h1),
    .pins_i                (pins),
    .primary_reset_out_o   (rst_out),
    .primary_reset_oe_n_o  (oe_n),
    .regulators_enable_o   (reg_en),
    .spread_spectrum_off_o (ss_off),
    .watchdog_fault_o      (fault)
  );

  // Shutdown build on the same pins
  window_watchdog_supervisor #(
    .SHUTDOWN     (1'h1),
    .FIRST_TICKS  (F),
    .CLOSED_TICKS (C),
    .OPEN_TICKS   (O),
    .RESET_TICKS  (R),
    .ENABLE_TICKS (E)
  ) i_dut_sd (
    .ref_clk_i             (clk),
    .reset_n_i             (reset_n),
    .clk_en_i              (1'h1),
    .pins_i                (pins),
    .primary_reset_out_o   (),
    .primary_reset_oe_n_o  (oe_n_sd),
    .regulators_enable_o   (reg_en_sd),
    .spread_spectrum_off_o (),
    .watchdog_fault_o      ()
  );

  host_trigger_model i_host (
    .ref_clk_i  (clk),
    .reset_n_i  (reset_n),
    .released_i (oe_n),
    .mode_i     (mode),
    .period_i   (per),
    .trigger_o  (trig)
  );

  // --------------------------------
  // Checking and closing
  // --------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("Counts: %0d checks, %0d failures", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Bounded wait for a reset pin level
  task automatic wait_oe(input logic lvl, output int t);
    int n;
    for (n = 0; n < 3000 && oe_n !== lvl; n++) @(posedge clk);
    if (n == 3000) begin
      n_fail++;
      $display("BAD %0t wait ran out", $time);
      print_verdict();
    end
    t = int'(oc);
  endtask

  // Watch for a fault pulse over a number of clocks
  task automatic watch(input int clocks, output bit hit, output int t);
    int n;
    hit = 1'h0;
    for (n = 0; n < clocks && !hit; n++) begin
      @(posedge clk);
      hit = (fault === 1'h1);
    end
    t = int'(oc);
  endtask

  task automatic do_reset();
    @(posedge clk);
    reset_n <= 1'h0;
    repeat (6) @(posedge clk);
    reset_n <= 1'h1;
  endtask

  // Model: tick of the first fault after release, zero for none
  function automatic int model_ticks(input int m, input int p);
    if (m == 0) return F;
    if (m == 2) return O;
    if (p <= C) return p;
    if (p >= O) return O;
    return 0;
  endfunction

  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic run_case(input int m, input int p);
    int t0;
    int t1;
    int e;
    int n;
    bit hit;
    e = model_ticks(m, p);
    mode <= 2'(m);
    per  <= 16'(p * 8);
    do_reset();
    wait_oe(1'h1, t0);
    watch((F + 10) * 8, hit, t1);
    check(hit, e != 0);
    if (hit) begin
      check((t1 - t0) / 8 >= e - 1 && (t1 - t0) / 8 <= e + 1, 1'h1);
      wait_oe(1'h0, t0);
      check(reg_en_sd, 1'h0);
      wait_oe(1'h1, t1);
      check((t1 - t0) / 8 >= R + 2 && (t1 - t0) / 8 <= R + 4, 1'h1);
      check(reg_en, 1'h1);
      // Shutdown build: regulators off, then reset delay
      for (n = 0; n < 400 && oe_n_sd !== 1'h1; n++) @(posedge clk);
      t1 = int'(oc);
      check((t1 - t0) / 8 >= E + R - 1 && (t1 - t0) / 8 <= E + R + 1, 1'h1);
      check(reg_en_sd, 1'h1);
    end
    $display("Case mode %0d period %0d ended", m, p);
  endtask

  task automatic run_straps();
    int t;
    bit hit;
    mode   <= 2'h0;
    tlow_v <= 1'h1;
    sync_v <= 1'h1;
    do_reset();
    wait_oe(1'h1, t);
    watch((F + 5) * 8, hit, t);
    check(hit, 1'h0);
    check(ss_off, 1'h1);
    sync_v <= 1'h0;
    repeat (12) @(posedge clk);
    check(oe_n, 1'h0);
    check(ss_off, 1'h0);
    tlow_v <= 1'h0;
    wait_oe(1'h1, t);
    // Rail out of window, then global fault
    for (int i = 0; i < 2; i++) begin
      rail_v <= (i != 0);
      gflt_v <= (i != 0);
      repeat (12) @(posedge clk);
      check(oe_n, 1'h0);
      check(rst_out, 1'h0);
      watch((F + 5) * 8, hit, t);
      check(hit, 1'h0);
      rail_v <= 1'h1;
      gflt_v <= 1'h0;
      wait_oe(1'h1, t);
    end
    $display("Case straps and supply causes ended");
  endtask

  initial begin
    run_case(0, 0);
    run_case(2, 0);
    for (int i = 0; i < 9; i++) begin
      run_case(1, tbl[i < 6 ? i : $unsigned($random(seed)) % 6]);
    end
    run_straps();
    print_verdict();
  end
endmodule
